// file: tb.sv
// Purpose: Self-checking bench for the watchdog and reset cause block
// Assumes: Slow oscillator rises once every four system clocks
// Notes:   Assertions live in the design; this bench judges the ports
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                     i_sys_clk = 1'b0;
    logic                     i_rst = 1'b1;
    logic [15:0]              i_ds_addr = 16'h0000;
    logic                     i_ds_wr = 1'b0;
    logic                     i_ds_rd = 1'b0;
    logic [5:0]               i_io_addr = 6'h00;
    logic                     i_io_wr = 1'b0;
    logic                     i_io_rd = 1'b0;
    logic [7:0]               i_wdata = 8'h00;
    logic [7:0]               o_rdata;
    logic                     i_wdr = 1'b0;
    logic                     i_gie = 1'b0;
    logic                     i_irq_ack = 1'b0;
    logic                     o_irq_req;
    logic                     o_wd_reset;
    logic                     i_osc_128k = 1'b0;
    logic                     i_always_on_fuse = 1'b1;
    watchdog_pkg::reset_src_t i_reset_src = 3'h0;
    int                       error_cnt = 0;
    int                       comparisons = 0;
    int                       rst_seen = 0;
    int                       base;
    int                       n;

    watchdog_reset_status dut (
        .i_sys_clk        (i_sys_clk),
        .i_rst            (i_rst),
        .i_ds_addr        (i_ds_addr),
        .i_ds_wr          (i_ds_wr),
        .i_ds_rd          (i_ds_rd),
        .i_io_addr        (i_io_addr),
        .i_io_wr          (i_io_wr),
        .i_io_rd          (i_io_rd),
        .i_wdata          (i_wdata),
        .o_rdata          (o_rdata),
        .i_wdr            (i_wdr),
        .i_gie            (i_gie),
        .i_irq_ack        (i_irq_ack),
        .o_irq_req        (o_irq_req),
        .o_wd_reset       (o_wd_reset),
        .i_osc_128k       (i_osc_128k),
        .i_always_on_fuse (i_always_on_fuse),
        .i_reset_src      (i_reset_src)
    );

    // ****************************************************************
    // Clocks and monitors
    // ****************************************************************
    initial
    begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // Fast oscillator keeps a full time-out near 8192 clocks
    initial
    begin
        forever #80 i_osc_128k = ~i_osc_128k;
    end

    always @(posedge i_sys_clk)
    begin
        if (o_wd_reset === 1'b1)
            rst_seen <= rst_seen + 1;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask

    // One strobe cycle; the caller lets an edge pass before the next
    task automatic acc(input logic io, input logic wr, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        i_ds_addr = a;
        i_io_addr = a[5:0];
        i_wdata = d;
        i_ds_wr = !io && wr;
        i_ds_rd = !io && !wr;
        i_io_wr = io && wr;
        i_io_rd = io && !wr;
        tick(1);
        {i_ds_wr, i_ds_rd, i_io_wr, i_io_rd} = 4'h0;
        q = o_rdata;
    endtask

    task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(io, 1'b1, a, d, q);
        tick(1);
    endtask

    task automatic rdc(input logic io, input logic [15:0] a, input logic [7:0] e,
                       input string w);
        logic [7:0] q;
        acc(io, 1'b0, a, 8'h00, q);
        chk(w, e, q);
        tick(1);
    endtask

    // Opening write, then gap+2 edges to the second write
    task automatic unlk(input logic [7:0] o, input logic [7:0] d, input int gap);
        wr(1'b0, 16'h0060, o);
        tick(gap);
        wr(1'b0, 16'h0060, d);
    endtask

    task automatic pulse(input int which);
        if (which == 0)
            i_wdr = 1'b1;
        else
            i_irq_ack = 1'b1;
        tick(1);
        i_wdr = 1'b0;
        i_irq_ack = 1'b0;
        tick(1);
    endtask

    task automatic src(input logic [2:0] s);
        i_reset_src = s;
        tick(1);
        i_reset_src = 3'h0;
        tick(1);
    endtask

    task automatic wait_hi(input logic irq, input int lim, output int k);
        k = 0;
        while (((irq ? o_irq_req : o_wd_reset) !== 1'b1) && k < lim)
        begin
            tick(1);
            k++;
        end
    endtask

    task automatic rst_dut;
        i_rst = 1'b1;
        tick(16);
        i_rst = 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        rdc(1'b0, 16'h0054, 8'h01, "cause ds");
        rdc(1'b1, 16'h0034, 8'h01, "cause io");
        rdc(1'b0, 16'h0060, 8'h00, "control");
        rdc(1'b0, 16'h0055, 8'h00, "unmapped");
        wr(1'b1, 16'h0035, 8'h00);
        rdc(1'b1, 16'h0034, 8'h01, "cause io miss");
    endtask

    task automatic t_cause;
        src(3'h4);
        rdc(1'b0, 16'h0054, 8'h11, "scan flag");
        src(3'h2);
        rdc(1'b0, 16'h0054, 8'h13, "pin flag");
        src(3'h1);
        rdc(1'b0, 16'h0054, 8'h17, "bod flag");
        wr(1'b1, 16'h0034, 8'h16);
        rdc(1'b1, 16'h0034, 8'h16, "por cleared");
        wr(1'b1, 16'h0034, 8'h00);
        rdc(1'b1, 16'h0034, 8'h00, "all cleared");
        src(3'h1);
        rdc(1'b0, 16'h0054, 8'h04, "por not set");
        rst_dut();
        rdc(1'b0, 16'h0054, 8'h01, "power-on");
    endtask

    task automatic t_unlock;
        wr(1'b0, 16'h0060, 8'h08);
        rdc(1'b0, 16'h0060, 8'h08, "enable set");
        wr(1'b0, 16'h0060, 8'h00);
        rdc(1'b0, 16'h0060, 8'h08, "locked clear");
        wr(1'b0, 16'h0060, 8'h0D);
        rdc(1'b0, 16'h0060, 8'h08, "locked period");
        pulse(0);
        unlk(8'h18, 8'h0D, 2);
        rdc(1'b0, 16'h0060, 8'h0D, "fourth cycle");
        unlk(8'h1D, 8'h00, 3);
        rdc(1'b0, 16'h0060, 8'h0D, "fifth cycle");
        wr(1'b0, 16'h0060, 8'h1D);
        rdc(1'b0, 16'h0060, 8'h1D, "window open");
        wr(1'b0, 16'h0060, 8'h00);
        rdc(1'b0, 16'h0060, 8'h00, "turned off");
    endtask

    task automatic t_irq;
        wr(1'b0, 16'h0060, 8'h40);
        i_gie = 1'b1;
        base = rst_seen;
        repeat (3)
        begin
            tick(6000);
            chk("early irq", 8'h00, 8'(o_irq_req));
            pulse(0);
        end
        wait_hi(1'b1, 9000, n);
        chk("irq delay", 8'h01, 8'(n > 8180 && n < 8210));
        rdc(1'b0, 16'h0060, 8'hC0, "irq flag");
        i_gie = 1'b0;
        tick(1);
        chk("irq no gie", 8'h00, 8'(o_irq_req));
        i_gie = 1'b1;
        tick(1);
        chk("irq gie", 8'h01, 8'(o_irq_req));
        wr(1'b0, 16'h0060, 8'hC0);
        chk("irq w1c", 8'h00, 8'(o_irq_req));
        rdc(1'b0, 16'h0060, 8'h40, "flag w1c");
        chk("no reset", 8'(base), 8'(rst_seen));
    endtask

    task automatic t_second;
        wr(1'b1, 16'h0034, 8'h00);
        wr(1'b0, 16'h0060, 8'h48);
        pulse(0);
        wait_hi(1'b1, 9000, n);
        chk("combined irq", 8'h01, 8'(o_irq_req));
        wait_hi(1'b0, 9000, n);
        chk("second delay", 8'h01, 8'(n > 8180 && n < 8210));
        tick(1);
        chk("pulse width", 8'h00, 8'(o_wd_reset));
        tick(2);
        rdc(1'b0, 16'h0054, 8'h08, "wdog flag");
        rdc(1'b0, 16'h0060, 8'h08, "forced en");
        unlk(8'h18, 8'h00, 2);
        rdc(1'b0, 16'h0060, 8'h08, "held en");
        wr(1'b1, 16'h0034, 8'h00);
        unlk(8'h18, 8'h00, 2);
        rdc(1'b0, 16'h0060, 8'h00, "disarmed");
    endtask

    task automatic t_fallback;
        wr(1'b0, 16'h0060, 8'h48);
        pulse(0);
        wait_hi(1'b1, 9000, n);
        pulse(1);
        chk("ack irq", 8'h00, 8'(o_irq_req));
        rdc(1'b0, 16'h0060, 8'h08, "ack clears");
        wait_hi(1'b0, 9000, n);
        chk("fallback", 8'h01, 8'(n > 8150 && n < 8210));
    endtask

    task automatic t_fuse;
        i_always_on_fuse = 1'b0;
        rst_dut();
        // Fuse synchroniser needs two clocks after release
        tick(2);
        rdc(1'b0, 16'h0060, 8'h08, "fuse en");
        wr(1'b0, 16'h0060, 8'h40);
        rdc(1'b0, 16'h0060, 8'h08, "fuse ien");
        pulse(0);
        wait_hi(1'b0, 9000, n);
        chk("fuse reset", 8'h01, 8'(n > 8180 && n < 8210));
        chk("fuse irq", 8'h00, 8'(o_irq_req));
    endtask

    // ****************************************************************
    // Sequence and verdict
    // ****************************************************************
    task automatic results;
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Roughly 70k clocks expected; cut off at 100k
    initial
    begin
        #4000000;
        error_cnt++;
        results();
    end

    initial
    begin
        rst_dut();
        t_regs();
        t_cause();
        t_unlock();
        t_irq();
        t_second();
        t_fallback();
        t_fuse();
        results();
    end
endmodule

// file: watchdog_map.svh
// Purpose: Offsets, field positions, reset values and counts of the watchdog block
// Assumes: Included by its bare name after the package
// Notes:   Definitions only
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCS_DS_OFF      16'h0054
`define RCS_IO_OFF      6'h34
`define WCS_DS_OFF      16'h0060

// ****************************************************************
// Field positions
// ****************************************************************
`define RCS_SCAN_BIT    4
`define RCS_WDOG_BIT    3
`define RCS_BOD_BIT     2
`define RCS_PIN_BIT     1
`define RCS_POR_BIT     0
`define WCS_IRQ_FLAG    7
`define WCS_IRQ_EN      6
`define WCS_PER_MSB     5
`define WCS_UNLOCK      4
`define WCS_RST_EN      3
`define WCS_PER_LO_H    2
`define WCS_PER_LO_L    0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define RCS_RESET       5'h00
`define RCS_POR_VALUE   5'h01
`define PER_RESET       4'h0
`define PER_BASE        21'h000800
`define PER_CODE_MAX    4'h9
`define UNLOCK_CYCLES   3'h4
`define READ_IDLE       8'h00

`endif

// file: watchdog_osc_tick.sv
// Purpose: Turns the slow oscillator pin into one-cycle ticks
// Assumes: Oscillator far slower than the system clock
// Notes:   Two-flop synchroniser, edge seen on the second flop only
module watchdog_osc_tick (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_osc,
    output logic      o_tick
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_osc;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // One tick per oscillator rise
    assign o_tick = sync_q & ~prev_q;
endmodule

// file: watchdog_pkg.sv
// Purpose: Types shared by the watchdog block
// Assumes: Nothing
// Notes:   Constants live in watchdog_map.svh
package watchdog_pkg;

    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_IRQ,
        MODE_RST,
        MODE_IRQ_RST
    } wd_mode_t;

    // Reset causes from the reset generator, one-cycle pulses
    typedef struct packed {
        logic scan;
        logic pin;
        logic bod;
    } reset_src_t;

    // Reset cause flags as they sit in the status register
    typedef struct packed {
        logic scan;
        logic wdog;
        logic bod;
        logic pin;
        logic por;
    } cause_flags_t;

endpackage

// file: watchdog_reset_status.sv
// Purpose: Watchdog timer, its control register and the reset cause register
// Assumes: i_rst is the power-on reset; other resets arrive as cause pulses
// Notes:   Read data is registered, valid the cycle after the read strobe
// What this block does
// - Scan-chain reset sets bit 4; power-on or a written zero clears it
// - Watchdog reset sets bit 3; power-on or a written zero clears it
// - Brown-out reset sets bit 2; power-on or a written zero clears it
// - Pin reset sets bit 1; power-on or a written zero clears it
// - Power-on sets bit 0; only a written zero clears it
// - Time-out in interrupt operation sets the interrupt flag, bit 7
// - Vector execution or a written one clears the interrupt flag
// - Interrupt taken only with global enable, bit 6 enable and flag pending
// - Vector in combined mode clears enable and flag, leaving reset mode
// - Combined mode: second time-out before the vector gives a system reset
// - Enable pair selects stopped, interrupt, reset or interrupt-then-reset
// - Programmed fuse forces reset mode whatever the enables hold
// - Clearing reset enable or changing period needs unlock; unlock lasts four clocks
// - Reset enable reads set while the watchdog reset flag is set
// - Period select bits 5 and 2:0; 2048 doubling to 1048576 cycles
// - Cause register at data offset 0x54 and short I/O offset 0x34
// - Control register at 0x60 reachable by data-space accesses only
// - Counter counts ticks of the separate slow oscillator
// - Unlock write sets unlock and enable together, then any writes in the next four clocks may change protected fields
// - Restart instruction clears the counter
// - Reset mode time-out gives a one-clock system reset pulse
`include "watchdog_map.svh"

module watchdog_reset_status (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst,
    input  wire logic [15:0]                i_ds_addr,
    input  wire logic                       i_ds_wr,
    input  wire logic                       i_ds_rd,
    input  wire logic [5:0]                 i_io_addr,
    input  wire logic                       i_io_wr,
    input  wire logic                       i_io_rd,
    input  wire logic [7:0]                 i_wdata,
    output logic      [7:0]                 o_rdata,
    input  wire logic                       i_wdr,
    input  wire logic                       i_gie,
    input  wire logic                       i_irq_ack,
    output logic                            o_irq_req,
    output logic                            o_wd_reset,
    input  wire logic                       i_osc_128k,
    input  wire logic                       i_always_on_fuse,
    input  wire watchdog_pkg::reset_src_t   i_reset_src
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Set wins over a clear arriving in the same cycle
    function automatic logic flag_next(input logic q, input logic set, input logic clr);
        return set | (q & ~clr);
    endfunction

    // Last count of a period; reserved codes run as the longest period
    function automatic logic [19:0] period_last(input logic [3:0] code);
        logic [3:0]  sel;
        logic [20:0] span;
        sel  = (code > `PER_CODE_MAX) ? `PER_CODE_MAX : code;
        span = `PER_BASE << sel;
        return span[19:0] - 20'h00001;
    endfunction

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic rcs_ds_hit;
    logic rcs_io_hit;
    logic wcs_ds_hit;
    logic rcs_wr;
    logic rcs_rd;
    logic wcs_wr;
    logic wcs_rd;

    assign rcs_ds_hit = (i_ds_addr == `RCS_DS_OFF);
    assign rcs_io_hit = (i_io_addr == `RCS_IO_OFF);
    // Short I/O cannot reach the control register
    assign wcs_ds_hit = (i_ds_addr == `WCS_DS_OFF);
    assign rcs_wr     = (i_ds_wr & rcs_ds_hit) | (i_io_wr & rcs_io_hit);
    assign rcs_rd     = (i_ds_rd & rcs_ds_hit) | (i_io_rd & rcs_io_hit);
    assign wcs_wr     = i_ds_wr & wcs_ds_hit;
    assign wcs_rd     = i_ds_rd & wcs_ds_hit;

    // ****************************************************************
    // Fuse synchroniser and oscillator ticks
    // ****************************************************************
    logic fuse_meta_q;
    logic fuse_q;
    logic fuse_prog;
    logic tick;

    // Fuse is static, but still crosses in through two flops
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            fuse_meta_q <= 1'b1;
            fuse_q      <= 1'b1;
        end
        else
        begin
            fuse_meta_q <= i_always_on_fuse;
            fuse_q      <= fuse_meta_q;
        end
    end

    assign fuse_prog = ~fuse_q;

    watchdog_osc_tick u_tick (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_osc     (i_osc_128k),
        .o_tick    (tick)
    );

    // ****************************************************************
    // Control register state
    // ****************************************************************
    logic                       timeout_irq_flag_q;
    logic                       timeout_irq_flag_d;
    logic                       timeout_irq_enable_q;
    logic                       timeout_irq_enable_d;
    logic                       wde_q;
    logic                       wde_d;
    logic [3:0]                 per_q;
    logic [3:0]                 per_d;
    logic [3:0]                 per_wr;
    logic                       unlock_active;
    logic                       unlock_start;
    logic                       wd_reset_q;
    logic                       sys_rst_evt;
    logic                       wde_eff;
    logic                       timeout_irq_enable_eff;
    watchdog_pkg::wd_mode_t     mode;
    watchdog_pkg::cause_flags_t flags_q;
    watchdog_pkg::cause_flags_t flags_d;

    // Any non-power-on reset returns the control register to its reset state
    assign sys_rst_evt = wd_reset_q | i_reset_src.scan | i_reset_src.pin | i_reset_src.bod;

    assign wde_eff  = wde_q | flags_q.wdog | fuse_prog;
    assign timeout_irq_enable_eff = timeout_irq_enable_q & ~fuse_prog;

    assign mode = fuse_prog            ? watchdog_pkg::MODE_RST :
                  (wde_eff & timeout_irq_enable_eff) ? watchdog_pkg::MODE_IRQ_RST :
                  timeout_irq_enable_eff             ? watchdog_pkg::MODE_IRQ :
                  wde_eff              ? watchdog_pkg::MODE_RST :
                                         watchdog_pkg::MODE_STOP;

    // Window opens only when unlock and enable are written as ones together
    assign unlock_start = wcs_wr & i_wdata[`WCS_UNLOCK] & i_wdata[`WCS_RST_EN];

    watchdog_unlock_window u_unlock (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_start   (unlock_start),
        .i_clear   (sys_rst_evt),
        .o_active  (unlock_active)
    );

    // ****************************************************************
    // Time-out counter
    // ****************************************************************
    logic [19:0] count_q;
    logic [19:0] count_d;
    logic        timeout;
    logic        set_timeout_irq_flag;
    logic        fire_rst;

    assign timeout = tick & (count_q == period_last(per_q))
                   & (mode != watchdog_pkg::MODE_STOP);

    assign count_d = (sys_rst_evt | i_wdr | (mode == watchdog_pkg::MODE_STOP)) ? 20'h00000 :
                     timeout ? 20'h00000 :
                     tick    ? count_q + 20'h00001 : count_q;

    always_comb
    begin
        set_timeout_irq_flag = 1'b0;
        fire_rst = 1'b0;
        unique case (mode)
            watchdog_pkg::MODE_STOP:
            begin
                set_timeout_irq_flag = 1'b0;
            end
            watchdog_pkg::MODE_IRQ:
            begin
                set_timeout_irq_flag = timeout;
            end
            watchdog_pkg::MODE_RST:
            begin
                fire_rst = timeout;
            end
            watchdog_pkg::MODE_IRQ_RST:
            begin
                // Pending interrupt not yet served: escalate to reset
                set_timeout_irq_flag = timeout & ~timeout_irq_flag_q;
                fire_rst = timeout & timeout_irq_flag_q;
            end
        endcase
    end

    // ****************************************************************
    // Next-state of the control fields
    // ****************************************************************
    logic ack_combined;

    assign ack_combined = i_irq_ack & (mode == watchdog_pkg::MODE_IRQ_RST);

    assign timeout_irq_flag_d = sys_rst_evt ? 1'b0 :
                    flag_next(timeout_irq_flag_q, set_timeout_irq_flag,
                              i_irq_ack | (wcs_wr & i_wdata[`WCS_IRQ_FLAG]));

    assign timeout_irq_enable_d = sys_rst_evt  ? 1'b0 :
                    ack_combined ? 1'b0 :
                    wcs_wr       ? i_wdata[`WCS_IRQ_EN] : timeout_irq_enable_q;

    // Setting the enable is always allowed; clearing needs the window
    assign wde_d = sys_rst_evt ? 1'b0 :
                   (wcs_wr & i_wdata[`WCS_RST_EN]) ? 1'b1 :
                   (wcs_wr & unlock_active)        ? 1'b0 : wde_q;

    assign per_wr = {i_wdata[`WCS_PER_MSB], i_wdata[`WCS_PER_LO_H:`WCS_PER_LO_L]};
    assign per_d  = sys_rst_evt ? `PER_RESET :
                    (wcs_wr & unlock_active) ? per_wr : per_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            timeout_irq_flag_q     <= 1'b0;
            timeout_irq_enable_q     <= 1'b0;
            wde_q      <= 1'b0;
            per_q      <= `PER_RESET;
            count_q    <= 20'h00000;
            wd_reset_q <= 1'b0;
        end
        else
        begin
            timeout_irq_flag_q     <= timeout_irq_flag_d;
            timeout_irq_enable_q     <= timeout_irq_enable_d;
            wde_q      <= wde_d;
            per_q      <= per_d;
            count_q    <= count_d;
            wd_reset_q <= fire_rst;
        end
    end

    assign o_wd_reset = wd_reset_q;
    assign o_irq_req  = i_gie & timeout_irq_enable_eff & timeout_irq_flag_q;

    // ****************************************************************
    // Reset cause flags
    // ****************************************************************
    logic [4:0] rcs_clr;

    // A written zero clears; a written one leaves the flag alone
    assign rcs_clr = rcs_wr ? ~i_wdata[4:0] : 5'h00;

    assign flags_d.scan = flag_next(flags_q.scan, i_reset_src.scan, rcs_clr[`RCS_SCAN_BIT]);
    assign flags_d.wdog = flag_next(flags_q.wdog, wd_reset_q, rcs_clr[`RCS_WDOG_BIT]);
    assign flags_d.bod  = flag_next(flags_q.bod, i_reset_src.bod, rcs_clr[`RCS_BOD_BIT]);
    assign flags_d.pin  = flag_next(flags_q.pin, i_reset_src.pin, rcs_clr[`RCS_PIN_BIT]);
    assign flags_d.por  = flag_next(flags_q.por, 1'b0, rcs_clr[`RCS_POR_BIT]);

    // Power-on clears every cause but its own
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            flags_q <= `RCS_POR_VALUE;
        else
            flags_q <= flags_d;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0] rcs_view;
    logic [7:0] wcs_view;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    assign rcs_view = {3'h0, flags_q};
    assign wcs_view = {timeout_irq_flag_q, timeout_irq_enable_eff, per_q[3], unlock_active, wde_eff, per_q[2:0]};
    assign rdata_d  = rcs_rd ? rcs_view :
                      wcs_rd ? wcs_view : `READ_IDLE;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            rdata_q <= `READ_IDLE;
        else
            rdata_q <= rdata_d;
    end

    assign o_rdata = rdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    wd_pulse_one_a: assert property (o_wd_reset |=> !o_wd_reset)
        else $error("watchdog reset pulse longer than one clock");

    wdog_flag_set_a: assert property (o_wd_reset |=> flags_q.wdog)
        else $error("watchdog reset did not set its cause flag");

    scan_flag_set_a: assert property (i_reset_src.scan |=> flags_q.scan)
        else $error("scan reset did not set its cause flag");

    por_flag_hold_a: assert property (flags_q.por && !(rcs_wr && !i_wdata[`RCS_POR_BIT])
                                      |=> flags_q.por)
        else $error("power-on flag lost without a written zero");

    enable_forced_a: assert property (flags_q.wdog |-> ##1 (o_rdata[`WCS_RST_EN] || !$past(wcs_rd)))
        else $error("reset enable read clear while watchdog flag set");

    irq_needs_flag_a: assert property (o_irq_req |-> i_gie && timeout_irq_flag_q && !fuse_prog)
        else $error("interrupt request without flag, enable or global enable");

    unlock_length_a: assert property (unlock_start && !sys_rst_evt |=> unlock_active[*4] ##1
                                      (!unlock_active || $past(unlock_start)))
        else $error("unlock window not four clocks long");

    period_locked_a: assert property (!unlock_active |=> $stable(per_q) || $past(sys_rst_evt))
        else $error("period changed outside the unlock window");

    combined_ack_a: assert property (ack_combined && !sys_rst_evt |=> !timeout_irq_enable_q && !timeout_irq_flag_q)
        else $error("vector in combined mode left enable or flag set");

    second_timeout_a: assert property (timeout && mode == watchdog_pkg::MODE_IRQ_RST && timeout_irq_flag_q
                                       |=> o_wd_reset)
        else $error("second time-out in combined mode gave no reset");

    fuse_forces_a: assert property (fuse_prog |-> mode == watchdog_pkg::MODE_RST)
        else $error("programmed fuse did not force reset mode");

    restart_clears_a: assert property (i_wdr |=> count_q == 20'h00000)
        else $error("restart did not clear the counter");

    cover_irq_mode: cover property (set_timeout_irq_flag ##[1:50] o_irq_req);
    cover_reset_mode: cover property (mode == watchdog_pkg::MODE_RST && timeout ##1 o_wd_reset);
    cover_escalate: cover property (timeout && timeout_irq_flag_q && mode == watchdog_pkg::MODE_IRQ_RST);
    cover_unlock_change: cover property (unlock_start ##[1:4] (wcs_wr && unlock_active));

endmodule

// file: watchdog_unlock_window.sv
// Purpose: Timed window during which protected fields may change
// Assumes: i_start is a single write strobe
// Notes:   Counted in system clocks
`include "watchdog_map.svh"

module watchdog_unlock_window (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_start,
    input  wire logic i_clear,
    output logic      o_active
);
    logic [2:0] left_q;
    logic [2:0] left_d;

    // Restart reloads; hardware closes the window after four clocks
    assign left_d = i_clear ? 3'h0 :
                    i_start ? `UNLOCK_CYCLES :
                    (left_q != 3'h0) ? left_q - 3'h1 : 3'h0;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            left_q <= 3'h0;
        else
            left_q <= left_d;
    end

    assign o_active = (left_q != 3'h0);
endmodule
